// *** frsf_host_model.sv ***
// frsf_host_model.sv: host that reads the three result bytes.
// assumes ready and direction from the device; gap sets slow reads.
`timescale 1ns/1ns
`default_nettype none
module frsf_host_model (
  input wire logic clk, go, ready, dir,
  input wire logic [1:0] gap,
  input wire logic [7:0] data_in,
  output logic rd, busy,
  output logic [23:0] got
);
  initial begin
    rd = 1'b0;
    busy = 1'b0;
    got = '0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy = 1'b1;
        for (int i = 0; i < 3; i++) begin
          repeat (gap) @(posedge clk);
          #1 rd = 1'b1;
          // read held until the device offers a byte outward
          do @(posedge clk); while (!(ready && dir));
          got[23 - 8 * i -: 8] = data_in;
          #1 rd = (gap == 2'h0 && i < 2);
        end
        busy = 1'b0;
      end
    end
  end
endmodule // frsf_host_model
`default_nettype wire

// *** frsf_map.vh ***
// frsf_map.vh: bit positions, reset values and timing counts for the result status bytes.
// assumes inclusion by the status flag module only; definitions only.
`ifndef FRSF_MAP_VH
`define FRSF_MAP_VH

// error status one
`define FRSF_E1_END_TRACK 7
`define FRSF_E1_UNUSED_HI 6
`define FRSF_E1_CRC 5
`define FRSF_E1_OVERRUN 4
`define FRSF_E1_UNUSED_LO 3
`define FRSF_E1_NOT_FOUND 2
`define FRSF_E1_WRITE_BLOCK 1
`define FRSF_E1_ID_ABSENT 0

// error status two
`define FRSF_E2_UNUSED 7
`define FRSF_E2_DELETED 6
`define FRSF_E2_DATA_CRC 5
`define FRSF_E2_CYL_MISMATCH 4
`define FRSF_E2_SCAN_EQUAL 3
`define FRSF_E2_SCAN_UNSAT 2
`define FRSF_E2_BAD_CYL 1
`define FRSF_E2_DATA_ABSENT 0

// drive line status
`define FRSF_DL_UNUSED 7
`define FRSF_DL_WPROT_HI 6
`define FRSF_DL_READY 5
`define FRSF_DL_TRACK0 4
`define FRSF_DL_WPROT_LO 3
`define FRSF_DL_HEAD 2
`define FRSF_DL_UNIT_HIGH 1
`define FRSF_DL_UNIT_LOW 0

`define FRSF_ERR_RESET 8'h00
`define FRSF_BAD_CYL_VALUE 8'hFF

// result byte index, in read order
`define FRSF_IDX_ONE 2'h0
`define FRSF_IDX_TWO 2'h1
`define FRSF_IDX_DRIVE 2'h2

// overrun window in nanoseconds, and derived cycles at 8 ns
`define FRSF_OVERRUN_NS 13000
`define FRSF_CLK_NS 8
`define FRSF_OVERRUN_CYC (`FRSF_OVERRUN_NS / `FRSF_CLK_NS)

`endif

// *** frsf_status.v ***
// frsf_status.v: result phase status bytes of a floppy controller, read via data register.
// assumes command engine strobes on ref_clk; drive lines arrive asynchronously.
`timescale 1ns/1ns
`default_nettype none
`include "frsf_map.vh"

module frsf_status #(
  parameter OVERRUN_CYC = `FRSF_OVERRUN_CYC
) (
  input wire ref_clk,
  input wire arst_n,
  // command engine
  input wire cmd_start,
  input wire [2:0] cmd_kind,
  input wire sector_past_end,
  input wire id_crc_fail,
  input wire data_crc_fail,
  input wire sector_missing,
  input wire id_field_bad,
  input wire index_pulse,
  input wire id_mark_seen,
  input wire data_mark_missing,
  input wire deleted_mark_seen,
  input wire [7:0] cyl_on_medium,
  input wire [7:0] internal_id_holding,
  input wire cyl_check,
  input wire scan_equal_hit,
  input wire scan_exhausted,
  input wire byte_pending,
  input wire byte_serviced,
  input wire write_attempt,
  input wire result_start,
  // drive side
  input wire write_protect_in,
  input wire track0_in,
  input wire head_side_bit,
  input wire unit_sel_high,
  input wire unit_sel_low,
  // host data register
  input wire data_rd,
  output wire host_transfer_ready,
  output wire transfer_direction,
  output reg [7:0] data_out,
  output wire result_done
);

  // command kinds
  localparam [2:0] CMD_READ = 3'h0;
  localparam [2:0] CMD_WRITE = 3'h1;
  localparam [2:0] CMD_WRITE_DEL = 3'h2;
  localparam [2:0] CMD_SCAN = 3'h3;
  localparam [2:0] CMD_READ_ID = 3'h4;
  localparam [2:0] CMD_READ_TRACK = 3'h5;
  localparam [2:0] CMD_FORMAT = 3'h6;
  localparam [2:0] CMD_OTHER = 3'h7;

  // result states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SEND = 2'h1;

  //////////////////////////////////////////////////////////////////////////////
  // drive input synchronisers
  reg [1:0] wp_sync_reg;
  reg [1:0] t0_sync_reg;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_sync_reg <= 2'h0;
      t0_sync_reg <= 2'h0;
    end else begin
      wp_sync_reg <= {wp_sync_reg[0], write_protect_in};
      t0_sync_reg <= {t0_sync_reg[0], track0_in};
    end
  end
  wire wp_level = wp_sync_reg[1];
  wire t0_level = t0_sync_reg[1];

  //////////////////////////////////////////////////////////////////////////////
  // event qualification
  function is_kind;
    input [2:0] kind;
    input [2:0] a;
    input [2:0] b;
    input [2:0] c;
    begin
      is_kind = (kind == a) || (kind == b) || (kind == c);
    end
  endfunction

  reg [2:0] kind_reg;
  reg [1:0] index_cnt_reg;
  reg [1:0] index_cnt_next;
  reg [12:0] wait_cnt_reg;
  reg [12:0] wait_cnt_next;

  // last count of the service window; counter is 13 bits, so the window must fit
  localparam [12:0] WAIT_LAST = OVERRUN_CYC[12:0] - 13'h1;

  wire cyl_differs = cyl_check && (cyl_on_medium != internal_id_holding);
  wire set_end = sector_past_end;
  wire set_crc = id_crc_fail || data_crc_fail;
  wire overrun_hit = byte_pending && !byte_serviced &&
                     (wait_cnt_reg == WAIT_LAST);
  wire nf_rw = sector_missing && is_kind(kind_reg, CMD_READ, CMD_WRITE_DEL, CMD_SCAN);
  wire nf_id = id_field_bad && (kind_reg == CMD_READ_ID);
  wire nf_trk = sector_missing && (kind_reg == CMD_READ_TRACK);
  wire set_wblk = write_attempt && wp_level &&
                  is_kind(kind_reg, CMD_WRITE, CMD_WRITE_DEL, CMD_FORMAT);
  wire id_absent = index_pulse && !id_mark_seen && (index_cnt_reg == 2'h1);
  wire set_del = deleted_mark_seen &&
                 is_kind(kind_reg, CMD_READ, CMD_SCAN, CMD_SCAN);
  wire set_cyl = cyl_differs;
  wire set_bad = cyl_differs && (cyl_on_medium == `FRSF_BAD_CYL_VALUE);
  wire set_nf = nf_rw || nf_id || nf_trk || cyl_differs;
  wire scan_cmd = (kind_reg == CMD_SCAN);

  // index pulses counted since last id mark
  // saturates at two, so a long search cannot wrap and hide the second pulse
  always @* begin
    index_cnt_next = index_cnt_reg;
    if (cmd_start || id_mark_seen)
      index_cnt_next = 2'h0;
    else if (index_pulse && index_cnt_reg != 2'h2)
      index_cnt_next = index_cnt_reg + 2'h1;
  end

  // host service window for each pending byte
  always @* begin
    wait_cnt_next = 13'h0;
    // any service or idle cycle restarts the window for the next byte
    if (byte_pending && !byte_serviced && wait_cnt_reg != WAIT_LAST)
      wait_cnt_next = wait_cnt_reg + 13'h1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // sticky flags; a set in the clearing cycle wins over the clear
  reg [7:0] err_one_reg;
  reg [7:0] err_two_reg;
  reg [7:0] err_one_next;
  reg [7:0] err_two_next;

  always @* begin
    err_one_next = cmd_start ? `FRSF_ERR_RESET : err_one_reg;
    err_two_next = cmd_start ? `FRSF_ERR_RESET : err_two_reg;
    if (set_end)
      err_one_next[`FRSF_E1_END_TRACK] = 1'b1;
    if (set_crc)
      err_one_next[`FRSF_E1_CRC] = 1'b1;
    if (overrun_hit)
      err_one_next[`FRSF_E1_OVERRUN] = 1'b1;
    if (set_nf)
      err_one_next[`FRSF_E1_NOT_FOUND] = 1'b1;
    if (set_wblk)
      err_one_next[`FRSF_E1_WRITE_BLOCK] = 1'b1;
    if (id_absent) begin
      err_one_next[`FRSF_E1_ID_ABSENT] = 1'b1;
      err_two_next[`FRSF_E2_DATA_ABSENT] = 1'b1;
    end
    if (set_del)
      err_two_next[`FRSF_E2_DELETED] = 1'b1;
    if (data_crc_fail)
      err_two_next[`FRSF_E2_DATA_CRC] = 1'b1;
    if (set_cyl)
      err_two_next[`FRSF_E2_CYL_MISMATCH] = 1'b1;
    if (scan_cmd && scan_equal_hit)
      err_two_next[`FRSF_E2_SCAN_EQUAL] = 1'b1;
    if (scan_cmd && scan_exhausted)
      err_two_next[`FRSF_E2_SCAN_UNSAT] = 1'b1;
    if (set_bad)
      err_two_next[`FRSF_E2_BAD_CYL] = 1'b1;
    if (data_mark_missing)
      err_two_next[`FRSF_E2_DATA_ABSENT] = 1'b1;
    // unused bits forced low whatever happened above
    err_one_next[`FRSF_E1_UNUSED_HI] = 1'b0;
    err_one_next[`FRSF_E1_UNUSED_LO] = 1'b0;
    err_two_next[`FRSF_E2_UNUSED] = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // named views of the staged flags; both error status bytes are built from these
  // staged values, so an event in the loading cycle is not lost
  wire end_track_flag = err_one_next[`FRSF_E1_END_TRACK];
  wire crc_fault_flag = err_one_next[`FRSF_E1_CRC];
  wire overrun_flag = err_one_next[`FRSF_E1_OVERRUN];
  wire sector_not_found_flag = err_one_next[`FRSF_E1_NOT_FOUND];
  wire write_blocked_flag = err_one_next[`FRSF_E1_WRITE_BLOCK];
  wire id_mark_absent_flag = err_one_next[`FRSF_E1_ID_ABSENT];
  wire deleted_mark_flag = err_two_next[`FRSF_E2_DELETED];
  wire data_field_crc_flag = err_two_next[`FRSF_E2_DATA_CRC];
  wire cylinder_mismatch_flag = err_two_next[`FRSF_E2_CYL_MISMATCH];
  wire scan_equal_flag = err_two_next[`FRSF_E2_SCAN_EQUAL];
  wire scan_unsatisfied_flag = err_two_next[`FRSF_E2_SCAN_UNSAT];
  wire bad_cylinder_flag = err_two_next[`FRSF_E2_BAD_CYL];
  wire data_mark_absent_flag = err_two_next[`FRSF_E2_DATA_ABSENT];

  wire [7:0] error_status_one;
  assign error_status_one[`FRSF_E1_END_TRACK] = end_track_flag;
  assign error_status_one[`FRSF_E1_UNUSED_HI] = 1'b0;
  assign error_status_one[`FRSF_E1_CRC] = crc_fault_flag;
  assign error_status_one[`FRSF_E1_OVERRUN] = overrun_flag;
  assign error_status_one[`FRSF_E1_UNUSED_LO] = 1'b0;
  assign error_status_one[`FRSF_E1_NOT_FOUND] = sector_not_found_flag;
  assign error_status_one[`FRSF_E1_WRITE_BLOCK] = write_blocked_flag;
  assign error_status_one[`FRSF_E1_ID_ABSENT] = id_mark_absent_flag;

  wire [7:0] error_status_two;
  assign error_status_two[`FRSF_E2_UNUSED] = 1'b0;
  assign error_status_two[`FRSF_E2_DELETED] = deleted_mark_flag;
  assign error_status_two[`FRSF_E2_DATA_CRC] = data_field_crc_flag;
  assign error_status_two[`FRSF_E2_CYL_MISMATCH] = cylinder_mismatch_flag;
  assign error_status_two[`FRSF_E2_SCAN_EQUAL] = scan_equal_flag;
  assign error_status_two[`FRSF_E2_SCAN_UNSAT] = scan_unsatisfied_flag;
  assign error_status_two[`FRSF_E2_BAD_CYL] = bad_cylinder_flag;
  assign error_status_two[`FRSF_E2_DATA_ABSENT] = data_mark_absent_flag;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_one_reg <= `FRSF_ERR_RESET;
      err_two_reg <= `FRSF_ERR_RESET;
      kind_reg <= CMD_OTHER;
      index_cnt_reg <= 2'h0;
      wait_cnt_reg <= 13'h0;
    end else begin
      err_one_reg <= err_one_next;
      err_two_reg <= err_two_next;
      if (cmd_start)
        kind_reg <= cmd_kind;
      index_cnt_reg <= index_cnt_next;
      wait_cnt_reg <= wait_cnt_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // drive line status, live
  // drive is never polled for ready; the bit is tied high
  wire drive_ready_bit = 1'b1;
  wire [7:0] drive_line_status;
  assign drive_line_status[`FRSF_DL_UNUSED] = 1'b0;
  assign drive_line_status[`FRSF_DL_WPROT_HI] = wp_level;
  assign drive_line_status[`FRSF_DL_READY] = drive_ready_bit;
  assign drive_line_status[`FRSF_DL_TRACK0] = t0_level;
  assign drive_line_status[`FRSF_DL_WPROT_LO] = wp_level;
  assign drive_line_status[`FRSF_DL_HEAD] = head_side_bit;
  assign drive_line_status[`FRSF_DL_UNIT_HIGH] = unit_sel_high;
  assign drive_line_status[`FRSF_DL_UNIT_LOW] = unit_sel_low;

  //////////////////////////////////////////////////////////////////////////////
  // result phase: three bytes out through the data register
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [1:0] idx_reg;
  reg [1:0] idx_next;
  reg done_reg;

  function [7:0] pick_byte;
    input [1:0] idx;
    input [7:0] one;
    input [7:0] two;
    input [7:0] drv;
    begin
      case (idx)
        `FRSF_IDX_ONE: pick_byte = one;
        `FRSF_IDX_TWO: pick_byte = two;
        default: pick_byte = drv;
      endcase
    end
  endfunction

  // reads outside the ready window are ignored
  wire take_read = (state_reg == ST_SEND) && data_rd;

  always @* begin
    state_next = state_reg;
    idx_next = idx_reg;
    case (state_reg)
      ST_IDLE: begin
        if (result_start) begin
          state_next = ST_SEND;
          idx_next = `FRSF_IDX_ONE;
        end
      end
      ST_SEND: begin
        if (take_read) begin
          if (idx_reg == `FRSF_IDX_DRIVE)
            state_next = ST_IDLE;
          else
            idx_next = idx_reg + 2'h1;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      idx_reg <= 2'h0;
      data_out <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      done_reg <= take_read && (idx_reg == `FRSF_IDX_DRIVE);
      // next byte staged so data_out is valid whenever ready is shown
      if (state_next == ST_SEND)
        data_out <= pick_byte(idx_next, error_status_one, error_status_two, drive_line_status);
      else if (take_read)
        data_out <= 8'h00;
    end
  end

  assign host_transfer_ready = (state_reg == ST_SEND);
  assign transfer_direction = (state_reg == ST_SEND);
  assign result_done = done_reg;

endmodule // frsf_status
`default_nettype wire

// *** frsf_status_monitor.sv ***
// frsf_status_monitor.sv: port assertions for the result byte reader.
// assumes bind onto frsf_status; one clock, async active-low reset.
`timescale 1ns/1ns
`default_nettype none
module frsf_status_monitor (
  input wire logic ref_clk, arst_n, result_start, data_rd, result_done,
  input wire logic head_side_bit, unit_sel_high, unit_sel_low,
  input wire logic host_transfer_ready, transfer_direction,
  input wire logic [7:0] data_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [1:0] idx_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) idx_reg <= 2'h0;
    else if (result_start) idx_reg <= 2'h0;
    else if (data_rd && host_transfer_ready) idx_reg <= idx_reg + 2'h1;
  end
  ////////////////////////////////////////
  wire show1 = host_transfer_ready && idx_reg == 2'h0;
  wire show2 = host_transfer_ready && idx_reg == 2'h1;
  wire show3 = host_transfer_ready && idx_reg == 2'h2;
  sequence s_last_read; show3 && data_rd; endsequence
  sequence s_closed; !host_transfer_ready && result_done ##1 !result_done; endsequence
  property p_dir; host_transfer_ready == transfer_direction; endproperty
  property p_open; result_start |=> host_transfer_ready && transfer_direction; endproperty
  property p_zero1; show1 |-> !data_out[6] && !data_out[3]; endproperty
  property p_zero2; show2 |-> !data_out[7]; endproperty
  property p_ready; show3 |-> data_out[5] && !data_out[7]; endproperty
  property p_wp; show3 |-> data_out[6] == data_out[3]; endproperty
  property p_sel;
    show3 && $past(idx_reg) == 2'h1 |->
      data_out[2:0] == $past({head_side_bit, unit_sel_high, unit_sel_low});
  endproperty
  property p_end; s_last_read |=> s_closed; endproperty
  a_dir: assert property (p_dir) else $error("direction differs from ready");
  a_open: assert property (p_open) else $error("no byte after result start");
  a_zero1: assert property (p_zero1) else $error("unused bit set in byte one");
  a_zero2: assert property (p_zero2) else $error("unused bit set in byte two");
  a_ready: assert property (p_ready) else $error("drive byte fixed bits wrong");
  a_wp: assert property (p_wp) else $error("write protect copies differ");
  a_sel: assert property (p_sel) else $error("head or unit bits wrong");
  a_end: assert property (p_end) else $error("phase did not close");
endmodule // frsf_status_monitor
`default_nettype wire

// *** tb.sv ***
// tb.sv: command sequences with expected result bytes.
// assumes the host model and monitor files compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic ref_clk, arst_n, go, pend, wp, t0, hs, uh, ul, rd, rdy, dir, done, busy;
  logic [2:0] kind;
  logic [1:0] gap;
  logic [7:0] cyl_med, dout;
  logic [15:0] ev;
  logic [23:0] got;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  // short overrun window keeps the run brief
  frsf_status #(.OVERRUN_CYC(8)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .cmd_start(ev[14]), .cmd_kind(kind), .sector_past_end(ev[0]), .id_crc_fail(ev[1]),
    .data_crc_fail(ev[2]), .sector_missing(ev[3]), .id_field_bad(ev[4]),
    .index_pulse(ev[5]), .id_mark_seen(ev[6]), .data_mark_missing(ev[7]),
    .deleted_mark_seen(ev[8]), .cyl_on_medium(cyl_med), .internal_id_holding(8'h03),
    .cyl_check(ev[9]), .scan_equal_hit(ev[10]), .scan_exhausted(ev[11]),
    .byte_pending(pend), .byte_serviced(ev[12]), .write_attempt(ev[13]),
    .result_start(ev[15]), .write_protect_in(wp), .track0_in(t0), .head_side_bit(hs),
    .unit_sel_high(uh), .unit_sel_low(ul), .data_rd(rd), .host_transfer_ready(rdy),
    .transfer_direction(dir), .data_out(dout), .result_done(done));
  frsf_host_model i_host (.clk(ref_clk), .go(go), .ready(rdy), .dir(dir), .gap(gap),
    .data_in(dout), .rd(rd), .busy(busy), .got(got));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pulse(input int i);
    @(posedge ref_clk);
    #1 ev[i] = 1'b1;
    @(posedge ref_clk);
    #1 ev[i] = 1'b0;
  endtask
  task automatic cmd(input logic [2:0] k);
    kind = k;
    pulse(14);
  endtask
  task automatic result(input string nm, input logic [7:0] e1, e2);
    pulse(15);
    go = 1'b1;
    @(posedge ref_clk);
    #1 go = 1'b0;
    while (busy) @(posedge ref_clk);
    check({nm, " err1"}, got[23:16], e1);
    check({nm, " err2"}, got[15:8], e2);
    check({nm, " drive"}, got[7:0], {1'b0, wp, 1'b1, t0, wp, hs, uh, ul});
    $display("test %s done", nm);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      conclude();
    end
  end
  ////////////////////////////////////////
  initial begin
    {arst_n, go, gap, ev, kind, pend, t0, uh} = '0;
    {wp, hs, ul} = 3'h7;
    cyl_med = 8'h03;
    repeat (8) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    cmd(3'h3); pulse(10); pulse(11); pulse(8);
    result("scan", 8'h00, 8'h4C);
    cmd(3'h0); pulse(0); pulse(2); pulse(3); pulse(7); pulse(8); pulse(10);
    result("read", 8'hA4, 8'h61);
    {t0, hs, uh, ul} = 4'hA;
    cyl_med = 8'hFF;
    cmd(3'h1); pulse(13); pulse(9); pulse(1); pulse(8);
    pend = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 pend = 1'b0;
    result("write", 8'h36, 8'h12);
    gap = 2'h2;
    cmd(3'h4); pulse(4); pulse(3); pulse(5); pulse(5);
    result("readid", 8'h05, 8'h01);
    cmd(3'h2); pulse(13); pulse(3);
    result("wrdel", 8'h06, 8'h00);
    wp = 1'b0;
    cmd(3'h5); pulse(3); pulse(5); pulse(6); pulse(5);
    result("track", 8'h04, 8'h00);
    cmd(3'h6); pulse(13);
    result("format", 8'h00, 8'h00);
    conclude();
  end
endmodule // tb
bind frsf_status frsf_status_monitor i_mon (.*);
`default_nettype wire
